// *** core/sbmtc_pkg.sv ***
// constants and carrier types for the bus-master transfer control
package sbmtc_pkg;
  localparam int CLK_PERIOD_NS  = 40;
  localparam int MSYNC_SETUP_NS = 150;
  localparam int MSYNC_SETUP_CYC = (MSYNC_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EOT_DELAY_NS   = 100;
  localparam int EOT_DELAY_CYC  = (EOT_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
                                  EOT_DELAY_NS / CLK_PERIOD_NS;
  localparam int TIMEOUT_US     = 22;
  localparam int TIMEOUT_CYC    = (TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  localparam int TMR_W          = 10;
  localparam int SEQ_W          = 3;

  localparam logic [TMR_W-1:0] TIMEOUT_LAST = TMR_W'(TIMEOUT_CYC - 1);
  localparam logic [SEQ_W-1:0] SETUP_LAST   = SEQ_W'(MSYNC_SETUP_CYC - 1);
  localparam logic [SEQ_W-1:0] EOT_LAST     = SEQ_W'(EOT_DELAY_CYC - 1);
  localparam logic [SEQ_W-1:0] SEQ_ZERO     = 3'h0;
  localparam logic [SEQ_W-1:0] SEQ_ONE      = 3'h1;
  localparam logic [TMR_W-1:0] TMR_ZERO     = 10'h000;
  localparam logic [TMR_W-1:0] TMR_ONE      = 10'h001;
  localparam logic [15:0]      WORD_ZERO    = 16'h0000;

  // transfer type codes, upper bit first
  localparam logic [1:0] XT_WORD_READ       = 2'h0;
  localparam logic [1:0] XT_READ_WITH_PAUSE = 2'h1;
  localparam logic [1:0] XT_WORD_WRITE      = 2'h2;
  localparam logic [1:0] XT_BYTE_WRITE      = 2'h3;
  localparam int         XT_WRITE_BIT       = 1;

  // microcode side of a transfer
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [1:0]  xtype;
  } sbmtc_req_t;

  // sampled bus lines, active high
  typedef struct packed {
    logic [15:0] data;
    logic        slave_sync;
    logic        bus_busy;
    logic        dma_request;
    logic        select_acknowledge;
    logic        parity_b;
  } sbmtc_bus_in_t;

  // bus drivers; an open-drain line is asserted while its oe_n is low
  typedef struct packed {
    logic [15:0] addr;
    logic        addr_oe_n;
    logic [15:0] data;
    logic        data_oe_n;
    logic        xfer_type_hi;
    logic        xfer_type_lo;
    logic        ctl_oe_n;
    logic        bus_busy_oe_n;
    logic        master_sync_oe_n;
    logic        select_ack_oe_n;
  } sbmtc_bus_out_t;

  function automatic logic sbmtc_is_write(input logic [1:0] xtype);
    return xtype[XT_WRITE_BIT];
  endfunction : sbmtc_is_write
endpackage : sbmtc_pkg

// *** core/sbmtc_timer.sv ***
// 22 us watchdog: counts while run is high, flags expiry
`timescale 1ns/1ns
module sbmtc_timer
  import sbmtc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_run,
  output logic      o_expired
);
  import sbmtc_pkg::*;

  logic [TMR_W-1:0] cnt_q;

  // restarts whenever run drops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q     <= TMR_ZERO;
      o_expired <= 1'b0;
    end else if (!i_run) begin
      cnt_q     <= TMR_ZERO;
      o_expired <= 1'b0;
    end else if (cnt_q == TIMEOUT_LAST) begin
      o_expired <= 1'b1;
    end else begin
      cnt_q <= cnt_q + TMR_ONE;
    end
  end
endmodule : sbmtc_timer

// *** core/sbmtc_select_acknowledge_guard.sv ***
// self-generated select acknowledge for a grant nobody answers
`timescale 1ns/1ns
module sbmtc_select_acknowledge_guard
  import sbmtc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_grant,
  input  wire logic i_halt_grant,
  output logic      o_self_ack
);
  import sbmtc_pkg::*;

  logic expired;

  // timer restarts from each grant; halt grants never time out
  sbmtc_timer u_tmr (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_run     (i_grant && !i_halt_grant),
    .o_expired (expired)
  );

  // dropping the grant releases the acknowledge
  assign o_self_ack = expired && i_grant;
endmodule : sbmtc_select_acknowledge_guard

// *** core/sbmtc_xfer_ctrl.sv ***
// bus-master transfer control: arbitration, handshake, clock inhibit
`timescale 1ns/1ns
module sbmtc_xfer_ctrl
  import sbmtc_pkg::*;
(
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_arst_n,
  input  wire logic                      i_transfer_request,
  input  wire logic                      i_tap,
  input  wire sbmtc_pkg::sbmtc_req_t     i_req,
  input  wire logic                      i_master_sync_allow,
  input  wire logic                      i_cache_hit,
  input  wire logic                      i_internal_mux_tristate_n,
  input  wire logic [15:0]               i_ext_data,
  input  wire logic                      i_grant_request,
  input  wire logic                      i_halt_pending_n,
  input  wire sbmtc_pkg::sbmtc_bus_in_t  i_bus,
  output sbmtc_pkg::sbmtc_bus_out_t      o_bus,
  output logic                           o_priority_grant_n,
  output logic                           o_dma_grant,
  output logic                           o_clock_inhibit_n,
  output logic                           o_msync_clock_gate,
  output logic                           o_end_of_transfer_n,
  output logic [15:0]                    o_rdata,
  output logic                           o_rdata_load,
  output logic                           o_parity_error,
  output logic                           o_bus_error,
  output logic                           o_force_service
);
  import sbmtc_pkg::*;

  typedef enum logic [2:0] {XS_IDLE, XS_SETUP, XS_SYNC, XS_EOT, XS_DONE} sbmtc_state_t;

  logic             rst_meta_q, rst_n;
  sbmtc_state_t     state_q;
  logic [SEQ_W-1:0] seq_q;
  sbmtc_req_t       req_q;
  logic             gate_q, msync_q, abort_q, rmw_hold_q;
  logic             pri_grant_q, dma_grant_q;
  logic             self_ack, slave_sync_expired, any_ack;
  logic             own, is_write, hit, in_use, start_ok, finish, rd_finish;

  // reset released through two flops
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  assign own      = (state_q == XS_SETUP) || (state_q == XS_SYNC) || (state_q == XS_EOT);
  assign is_write = sbmtc_is_write(req_q.xtype);
  assign hit      = i_cache_hit && (req_q.xtype == XT_WORD_READ);
  assign any_ack  = i_bus.select_acknowledge || self_ack;

  // bus-in-use: pause hold overrides all but slave sync
  always_comb begin
    in_use = i_bus.dma_request || i_bus.bus_busy
          || (dma_grant_q && !i_bus.select_acknowledge && !i_bus.bus_busy)
          || (i_bus.select_acknowledge && !i_bus.bus_busy);
    if (rmw_hold_q) begin
      in_use = 1'b0;
    end
    in_use = in_use || i_bus.slave_sync;
  end

  assign start_ok  = (state_q == XS_IDLE) && i_transfer_request && !in_use;
  assign rd_finish = (state_q == XS_EOT) && (seq_q == EOT_LAST);
  assign finish    = rd_finish
                  || ((state_q == XS_SYNC) && i_bus.slave_sync && is_write);

  // transfer sequencer
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= XS_IDLE;
      seq_q   <= SEQ_ZERO;
    end else begin
      unique case (state_q)
        XS_IDLE: begin
          seq_q <= SEQ_ZERO;
          if (start_ok) begin
            state_q <= XS_SETUP;
          end
        end
        XS_SETUP: begin
          if (seq_q != SETUP_LAST) begin
            seq_q <= seq_q + SEQ_ONE;
          end
          if (gate_q && hit) begin
            state_q <= XS_DONE;
          end else if (gate_q && (is_write || i_master_sync_allow)) begin
            state_q <= XS_SYNC;
          end
        end
        XS_SYNC: begin
          seq_q <= SEQ_ZERO;
          if (slave_sync_expired) begin
            state_q <= XS_DONE;
          end else if (i_bus.slave_sync) begin
            state_q <= is_write ? XS_DONE : XS_EOT;
          end
        end
        XS_EOT: begin
          seq_q <= seq_q + SEQ_ONE;
          if (rd_finish) begin
            state_q <= XS_DONE;
          end
        end
        XS_DONE: begin
          if (!i_transfer_request) begin
            state_q <= XS_IDLE;
          end
        end
      endcase
    end
  end

  // request captured at start so bus lines come from flops
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= '0;
    end else if (start_ok) begin
      req_q <= i_req;
    end
  end

  // sync clock gate: true once setup time has elapsed
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= (state_q == XS_SETUP) && (seq_q == SETUP_LAST);
    end
  end

  // master sync latch
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      msync_q <= 1'b0;
    end else if (state_q == XS_SETUP) begin
      msync_q <= gate_q && !hit && (is_write || i_master_sync_allow);
    end else if (i_bus.slave_sync || slave_sync_expired || state_q != XS_SYNC) begin
      msync_q <= 1'b0;
    end
  end

  sbmtc_timer u_slave_sync_tmr (
    .i_clk     (i_sys_clk),
    .i_rst_n   (rst_n),
    .i_run     (msync_q && !i_bus.slave_sync),
    .o_expired (slave_sync_expired)
  );

  // timeout latch; held until the request is withdrawn
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      abort_q         <= 1'b0;
      o_bus_error     <= 1'b0;
      o_force_service <= 1'b0;
    end else begin
      o_bus_error     <= slave_sync_expired && !abort_q;
      o_force_service <= slave_sync_expired && !abort_q;
      if (slave_sync_expired) begin
        abort_q <= 1'b1;
      end else if (!i_transfer_request) begin
        abort_q <= 1'b0;
      end
    end
  end

  // pause hold: from a read-with-pause until its write ends or slave sync times out
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rmw_hold_q <= 1'b0;
    end else if (slave_sync_expired) begin
      rmw_hold_q <= 1'b0;
    end else if (start_ok && i_req.xtype == XT_READ_WITH_PAUSE) begin
      rmw_hold_q <= 1'b1;
    end else if (finish && is_write) begin
      rmw_hold_q <= 1'b0;
    end
  end

  // end of transfer pulse, read data and parity
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_end_of_transfer_n <= 1'b1;
      o_rdata_load        <= 1'b0;
      o_rdata             <= WORD_ZERO;
      o_parity_error      <= 1'b0;
    end else begin
      o_end_of_transfer_n <= !finish;
      o_rdata_load        <= rd_finish || (state_q == XS_SETUP && gate_q && hit);
      o_parity_error      <= (state_q == XS_SYNC) && i_bus.slave_sync
                             && !is_write && i_bus.parity_b;
      if (state_q == XS_SETUP && gate_q && hit) begin
        o_rdata <= i_ext_data;
      end else if (state_q == XS_SYNC && i_bus.slave_sync && !is_write) begin
        o_rdata <= i_internal_mux_tristate_n ? i_bus.data : i_ext_data;
      end
    end
  end

  // grants; any acknowledge drops them
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_grant_q <= 1'b0;
      pri_grant_q <= 1'b0;
    end else begin
      if (any_ack) begin
        dma_grant_q <= 1'b0;
        pri_grant_q <= 1'b0;
      end else if (!dma_grant_q && !pri_grant_q && !own) begin
        dma_grant_q <= i_bus.dma_request;
        pri_grant_q <= !i_bus.dma_request && i_grant_request && !rmw_hold_q
                       && !i_bus.bus_busy;
      end
    end
  end

  sbmtc_select_acknowledge_guard u_select_acknowledge (
    .i_clk        (i_sys_clk),
    .i_rst_n      (rst_n),
    .i_grant      (dma_grant_q || pri_grant_q),
    .i_halt_grant (pri_grant_q && !i_halt_pending_n),
    .o_self_ack   (self_ack)
  );

  // clock inhibit; held through setup, sync and the read release delay
  assign o_clock_inhibit_n = !(i_transfer_request && i_tap && !abort_q
                               && ((state_q == XS_SETUP)
                                   || (msync_q && !i_bus.slave_sync)
                                   || (state_q == XS_EOT))
                               && (!hit || !gate_q));

  assign o_msync_clock_gate = gate_q;
  assign o_priority_grant_n = !pri_grant_q;
  assign o_dma_grant        = dma_grant_q;

  always_comb begin
    o_bus                  = '0;
    o_bus.addr             = req_q.addr;
    o_bus.data             = req_q.wdata;
    o_bus.xfer_type_hi     = req_q.xtype[1];
    o_bus.xfer_type_lo     = req_q.xtype[0];
    o_bus.addr_oe_n        = !own;
    o_bus.ctl_oe_n         = !own;
    o_bus.data_oe_n        = !(own && is_write);
    o_bus.bus_busy_oe_n    = !(own || rmw_hold_q);
    o_bus.master_sync_oe_n = !msync_q;
    o_bus.select_ack_oe_n  = !self_ack;
  end

  // checks
  sequence s_setup_held;
    (state_q == XS_SETUP) [*4];
  endsequence
  sequence s_read_release;
    (state_q == XS_EOT) ##1 (state_q == XS_EOT) ##1 !o_end_of_transfer_n;
  endsequence

  property p_inhibit_cause;
    @(posedge i_sys_clk) disable iff (!rst_n)
      !o_clock_inhibit_n |-> i_transfer_request && i_tap && !abort_q;
  endproperty
  a_inhibit_cause: assert property (p_inhibit_cause) else $error("inhibit without cause");

  property p_start_free;
    @(posedge i_sys_clk) disable iff (!rst_n)
      $rose(own) && !$past(rmw_hold_q) |->
        $past(!i_bus.dma_request && !i_bus.bus_busy && !i_bus.slave_sync);
  endproperty
  a_start_free: assert property (p_start_free) else $error("start on busy bus");

  property p_drivers_on;
    @(posedge i_sys_clk) disable iff (!rst_n)
      own |-> !o_bus.addr_oe_n && !o_bus.ctl_oe_n && !o_bus.bus_busy_oe_n;
  endproperty
  a_drivers_on: assert property (p_drivers_on) else $error("drivers off while owning");

  property p_data_write_only;
    @(posedge i_sys_clk) disable iff (!rst_n)
      !o_bus.data_oe_n |-> o_bus.xfer_type_hi && own;
  endproperty
  a_data_write_only: assert property (p_data_write_only) else $error("data on read");

  property p_msync_setup;
    @(posedge i_sys_clk) disable iff (!rst_n)
      $rose(msync_q) |-> $past(own, 5) && $past(own, 1);
  endproperty
  a_msync_setup: assert property (p_msync_setup) else $error("master sync too early");

  property p_setup_first;
    @(posedge i_sys_clk) disable iff (!rst_n)
      $rose(state_q == XS_SETUP) |-> s_setup_held;
  endproperty
  a_setup_first: assert property (p_setup_first) else $error("setup cut short");

  property p_read_release;
    @(posedge i_sys_clk) disable iff (!rst_n)
      (state_q == XS_SYNC) && i_bus.slave_sync && !is_write && !slave_sync_expired
        |-> ##1 s_read_release;
  endproperty
  a_read_release: assert property (p_read_release) else $error("read release timing");

  property p_write_release;
    @(posedge i_sys_clk) disable iff (!rst_n)
      (state_q == XS_SYNC) && i_bus.slave_sync && is_write && !slave_sync_expired
        |-> ##1 !o_end_of_transfer_n && !msync_q;
  endproperty
  a_write_release: assert property (p_write_release) else $error("write release timing");

  property p_timeout_abort;
    @(posedge i_sys_clk) disable iff (!rst_n)
      $rose(slave_sync_expired) |-> ##1 abort_q && o_bus_error && o_force_service && !msync_q;
  endproperty
  a_timeout_abort: assert property (p_timeout_abort) else $error("timeout not handled");

  property p_self_ack_rule;
    @(posedge i_sys_clk) disable iff (!rst_n)
      self_ack |-> (dma_grant_q || pri_grant_q) && !(pri_grant_q && !i_halt_pending_n)
               ##1 !dma_grant_q && !pri_grant_q;
  endproperty
  a_self_ack_rule: assert property (p_self_ack_rule) else $error("bad self acknowledge");

  property p_grant_quiet;
    @(posedge i_sys_clk) disable iff (!rst_n)
      $rose(dma_grant_q || pri_grant_q) |-> !self_ack [*8];
  endproperty
  a_grant_quiet: assert property (p_grant_quiet) else $error("early self acknowledge");

  property p_pause_busy;
    @(posedge i_sys_clk) disable iff (!rst_n)
      rmw_hold_q |-> !o_bus.bus_busy_oe_n;
  endproperty
  a_pause_busy: assert property (p_pause_busy) else $error("pause without busy");
endmodule : sbmtc_xfer_ctrl

// *** verif/sbmtc_bus_partner.sv ***
// bus slave and second bus master model facing the transfer control
`timescale 1ns/1ns
module sbmtc_bus_partner
  import sbmtc_pkg::*;
(
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  input  wire sbmtc_pkg::sbmtc_bus_out_t i_dev,
  input  wire logic                      i_priority_grant_n,
  input  wire logic                      i_dma_grant,
  input  wire logic [3:0]                i_delay,
  input  wire logic [3:0]                i_linger,
  input  wire logic                      i_mute,
  input  wire logic                      i_parity_bad,
  input  wire logic                      i_dma_go,
  input  wire logic                      i_ack_grant,
  output sbmtc_pkg::sbmtc_bus_in_t       o_lines
);
  logic [15:0] mem_q [16];
  logic [15:0] data_q;
  logic [3:0]  cnt_q;
  logic [3:0]  lin_q;
  logic [1:0]  mst_q;
  logic        ssync_q;
  logic        drive_q;
  logic        par_q;
  logic        select_acknowledge_q;
  logic        busy_q;
  logic        req_q;
  logic [3:0]  idx;
  logic        msync;

  assign idx   = i_dev.addr[4:1];
  assign msync = ~i_dev.master_sync_oe_n;
  // select acknowledge is a wired line shared with the device's own driver
  assign o_lines = {data_q, ssync_q, busy_q, req_q, select_acknowledge_q | ~i_dev.select_ack_oe_n,
                    ssync_q & par_q};

  // slave: answers master sync after a delay, keeps slave sync for a linger time
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mem_q   <= '{default: 16'h0000};
      data_q  <= 16'h0000;
      cnt_q   <= 4'h0;
      lin_q   <= 4'h0;
      ssync_q <= 1'h0;
      drive_q <= 1'h0;
      par_q   <= 1'h0;
    end else begin
      // released data lines never keep the last value
      if (!drive_q) data_q <= ~data_q;
      if (!ssync_q && msync && !i_mute) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == i_delay) begin
          ssync_q <= 1'h1;
          cnt_q   <= 4'h0;
          lin_q   <= i_linger;
          par_q   <= i_parity_bad;
          drive_q <= i_dev.data_oe_n;
          if (i_dev.data_oe_n) data_q <= mem_q[idx];
          else if (i_dev.xfer_type_lo) mem_q[idx] <= {mem_q[idx][15:8], i_dev.data[7:0]};
          else mem_q[idx] <= i_dev.data;
        end
      end else if (ssync_q && !msync) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == lin_q) begin
          ssync_q <= 1'h0;
          drive_q <= 1'h0;
          cnt_q   <= 4'h0;
        end
      end else cnt_q <= 4'h0;
    end
  end

  // second master: request, acknowledge a grant, then take the bus briefly
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mst_q  <= 2'h0;
      select_acknowledge_q <= 1'h0;
      busy_q <= 1'h0;
      req_q  <= 1'h0;
    end else begin
      if (i_dma_go && mst_q == 2'h0) req_q <= 1'h1;
      case (mst_q)
        2'h0: if ((i_dma_grant || !i_priority_grant_n) && i_ack_grant) begin
          select_acknowledge_q <= 1'h1;
          req_q  <= 1'h0;
          mst_q  <= 2'h1;
        end
        2'h1: if (!i_dma_grant && i_priority_grant_n && i_dev.bus_busy_oe_n && !ssync_q) begin
          busy_q <= 1'h1;
          mst_q  <= 2'h2;
        end
        2'h2: begin
          select_acknowledge_q <= 1'h0;
          mst_q  <= 2'h3;
        end
        default: begin
          busy_q <= 1'h0;
          mst_q  <= 2'h0;
        end
      endcase
    end
  end
endmodule : sbmtc_bus_partner

// *** verif/sbmtc_xfer_ctrl_tb_top.sv ***
// self-checking bench for the bus-master transfer control
`timescale 1ns/1ns
`define SBMTC_CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value %s exp %0h got %0h", nm, (e), (g)); end end
module sbmtc_xfer_ctrl_tb_top;
  import sbmtc_pkg::*;
  typedef struct {
    logic [1:0]  xt;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [3:0]  dly;
    logic [3:0]  lin;
    logic        hit;
    logic        par;
    logic        dma;
    logic        mute;
  } sbmtc_row_t;
  logic           clk, arst_n, xfer_rq, tap, allow, hit, mux_n, grant_rq, halt_n;
  logic           pgrant_n, dgrant, inh_n, gate, eot_n, rload, perr, berr, fsvc;
  logic           mute, pbad, dma_go, ack, blk_q, idle_q, hold;
  logic [15:0]    ext, rdata;
  logic [3:0]     dly, lin;
  sbmtc_req_t     req;
  sbmtc_bus_in_t  bus_in;
  sbmtc_bus_out_t bus_out;
  int             bad_count, num_checks, n, m;
  sbmtc_row_t     rows [11] = '{
    '{XT_WORD_WRITE, 16'h0004, 16'hA5C3, 16'h0000, 4'h0, 4'h0, 1'h0, 1'h0, 1'h0, 1'h0},
    '{XT_BYTE_WRITE, 16'h0006, 16'h1234, 16'h0000, 4'h2, 4'h8, 1'h0, 1'h0, 1'h0, 1'h0},
    '{XT_WORD_READ, 16'h0004, 16'h0000, 16'hA5C3, 4'h0, 4'h0, 1'h0, 1'h1, 1'h0, 1'h0},
    '{XT_WORD_READ, 16'h0006, 16'h0000, 16'h0034, 4'h5, 4'h0, 1'h0, 1'h0, 1'h0, 1'h0},
    '{XT_WORD_WRITE, 16'h0008, 16'h00FF, 16'h0000, 4'h0, 4'h0, 1'h0, 1'h1, 1'h0, 1'h0},
    '{XT_WORD_READ, 16'h0008, 16'h0000, 16'hBEEF, 4'h0, 4'h0, 1'h1, 1'h0, 1'h0, 1'h0},
    '{XT_WORD_READ, 16'h0008, 16'h0000, 16'h00FF, 4'h1, 4'h0, 1'h0, 1'h0, 1'h1, 1'h0},
    '{XT_READ_WITH_PAUSE, 16'h0004, 16'h0000, 16'hA5C3, 4'h0, 4'h0, 1'h0, 1'h0, 1'h0, 1'h0},
    '{XT_WORD_WRITE, 16'h0004, 16'h5A3C, 16'h0000, 4'h0, 4'h0, 1'h0, 1'h0, 1'h1, 1'h0},
    '{XT_WORD_READ, 16'h0004, 16'h0000, 16'h5A3C, 4'h0, 4'h0, 1'h0, 1'h0, 1'h0, 1'h0},
    '{XT_WORD_WRITE, 16'h000A, 16'h7777, 16'h0000, 4'h0, 4'h0, 1'h0, 1'h0, 1'h0, 1'h1}};

  sbmtc_xfer_ctrl dut_u (
    .i_sys_clk                 (clk),
    .i_arst_n                  (arst_n),
    .i_transfer_request        (xfer_rq),
    .i_tap                     (tap),
    .i_req                     (req),
    .i_master_sync_allow       (allow),
    .i_cache_hit               (hit),
    .i_internal_mux_tristate_n (mux_n),
    .i_ext_data                (ext),
    .i_grant_request           (grant_rq),
    .i_halt_pending_n          (halt_n),
    .i_bus                     (bus_in),
    .o_bus                     (bus_out),
    .o_priority_grant_n        (pgrant_n),
    .o_dma_grant               (dgrant),
    .o_clock_inhibit_n         (inh_n),
    .o_msync_clock_gate        (gate),
    .o_end_of_transfer_n       (eot_n),
    .o_rdata                   (rdata),
    .o_rdata_load              (rload),
    .o_parity_error            (perr),
    .o_bus_error               (berr),
    .o_force_service           (fsvc)
  );

  sbmtc_bus_partner part_u (
    .i_clk              (clk),
    .i_rst_n            (arst_n),
    .i_dev              (bus_out),
    .i_priority_grant_n (pgrant_n),
    .i_dma_grant        (dgrant),
    .i_delay            (dly),
    .i_linger           (lin),
    .i_mute             (mute),
    .i_parity_bad       (pbad),
    .i_dma_go           (dma_go),
    .i_ack_grant        (ack),
    .o_lines            (bus_in)
  );

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  // a start must never follow an edge that saw the bus in use
  always @(posedge clk) begin
    blk_q  <= bus_in.slave_sync | (!hold & (bus_in.dma_request | bus_in.bus_busy | dgrant |
              (bus_in.select_acknowledge & !bus_in.bus_busy)));
    idle_q <= bus_out.addr_oe_n;
  end
  always @(negedge clk) begin
    if (arst_n && idle_q === 1'h1 && bus_out.addr_oe_n === 1'h0) begin
      `SBMTC_CHK("start_while_in_use", 1'h0, blk_q)
    end
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic give_up(input string what);
    bad_count++;
    $display("wrong value %s exp done got timeout", what);
    stop_test();
  endtask : give_up

  task automatic run_row(input sbmtc_row_t r);
    int          k, tail, setup, ms_n, early, par_n, eot_c, err_n, fs_n;
    bit          lines, inh, gchk, schk, rd;
    logic [15:0] got;
    rd   = !r.xt[1];
    dly  = r.dly;
    lin  = r.lin;
    mute = r.mute;
    pbad = r.par;
    if (r.dma) begin
      dma_go = 1'h1;
      @(negedge clk);
      dma_go = 1'h0;
    end
    req     = '{r.addr, r.wdata, r.xt};
    xfer_rq = 1'h1;
    tap     = 1'h1;
    hit     = r.hit;
    mux_n   = !r.hit;
    ext     = r.hit ? r.rdata : ~r.rdata;
    tail    = 3;
    while (tail > 0) begin
      @(negedge clk);
      k++;
      if (k >= 700) give_up("row end");
      if (lines && bus_out.addr_oe_n === 1'h1) tail--;
      if (!lines && bus_out.addr_oe_n === 1'h0) begin
        lines = 1'h1;
        `SBMTC_CHK("xfer_type", r.xt, {bus_out.xfer_type_hi, bus_out.xfer_type_lo})
        `SBMTC_CHK("data_oe_n", !r.xt[1], bus_out.data_oe_n)
        `SBMTC_CHK("addr", r.addr, bus_out.addr)
      end
      if (lines && ms_n == 0 && bus_out.master_sync_oe_n === 1'h1) setup++;
      if (bus_out.master_sync_oe_n === 1'h0) ms_n++;
      if (bus_out.master_sync_oe_n === 1'h0 && !allow && rd) early++;
      if (inh_n === 1'h0) inh = 1'h1;
      if (r.hit && gate === 1'h1 && !gchk) begin
        gchk = 1'h1;
        `SBMTC_CHK("hit_clock_restart", 1'h1, inh_n)
      end
      if (!rd && bus_in.slave_sync && !schk) begin
        schk = 1'h1;
        `SBMTC_CHK("write_clock_release", 1'h1, inh_n)
      end
      if (perr === 1'h1) par_n++;
      if (rload === 1'h1) got = rdata;
      if (eot_n === 1'h0) eot_c++;
      if (berr === 1'h1) err_n++;
      if (fsvc === 1'h1) fs_n++;
      if (k == 6 && rd) allow = 1'h1;
    end
    `SBMTC_CHK("ownership", 1'h1, lines)
    `SBMTC_CHK("clock_stop", 1'h1, inh)
    `SBMTC_CHK("msync_used", !r.hit, ms_n > 0)
    `SBMTC_CHK("msync_before_allow", 0, early)
    if (!r.hit) `SBMTC_CHK("setup_ok", 1'h1, setup >= MSYNC_SETUP_CYC)
    `SBMTC_CHK("parity_error", r.par & rd, par_n > 0)
    `SBMTC_CHK("bus_error", r.mute, err_n > 0)
    `SBMTC_CHK("force_service", r.mute, fs_n > 0)
    if (!r.mute) `SBMTC_CHK("end_of_transfer", !r.hit, eot_c)
    if (rd) `SBMTC_CHK("read_data", r.rdata, got)
    `SBMTC_CHK("clock_released", 1'h1, inh_n)
    xfer_rq = 1'h0;
    tap     = 1'h0;
    hit     = 1'h0;
    allow   = 1'h0;
    hold    = (r.xt == XT_READ_WITH_PAUSE) | (hold & rd);
    @(negedge clk);
    `SBMTC_CHK("busy_hold", !hold, bus_out.bus_busy_oe_n)
  endtask : run_row

  initial begin
    {clk, arst_n, xfer_rq, tap, allow, hit, grant_rq, mute, pbad, dma_go, hold} = '0;
    {mux_n, halt_n, ack} = 3'h7;
    {ext, req, dly, lin} = '0;
    bad_count  = 0;
    num_checks = 0;
    repeat (3) @(negedge clk);
    `SBMTC_CHK("reset_oe", 6'h3F, {bus_out.addr_oe_n, bus_out.data_oe_n, bus_out.ctl_oe_n,
               bus_out.bus_busy_oe_n, bus_out.master_sync_oe_n, bus_out.select_ack_oe_n})
    `SBMTC_CHK("reset_outputs", 8'hE0, {pgrant_n, eot_n, inh_n, dgrant, rload, perr, berr, fsvc})
    `SBMTC_CHK("reset_rdata", 16'h0000, rdata)
    arst_n = 1'h1;
    repeat (3) @(negedge clk);
    $display("test reset done");
    foreach (rows[i]) begin
      run_row(rows[i]);
      $display("test row %0d done", i);
    end
    // unanswered dma grant gets a self acknowledge after the timeout
    ack    = 1'h0;
    dma_go = 1'h1;
    @(negedge clk);
    dma_go = 1'h0;
    for (n = 0; dgrant !== 1'h1; n++) begin
      if (n >= 10) give_up("dma grant");
      @(negedge clk);
    end
    for (n = 0; bus_out.select_ack_oe_n !== 1'h0; n++) begin
      if (n >= 700) give_up("self ack");
      @(negedge clk);
    end
    `SBMTC_CHK("self_ack_cycles", TIMEOUT_CYC, n)
    @(negedge clk);
    `SBMTC_CHK("grant_drop", 2'h0, {dgrant, ~bus_out.select_ack_oe_n})
    ack = 1'h1;
    repeat (12) @(negedge clk);
    $display("test grant timeout done");
    // halt grant is never timed out
    ack      = 1'h0;
    halt_n   = 1'h0;
    grant_rq = 1'h1;
    for (n = 0; pgrant_n !== 1'h0; n++) begin
      if (n >= 10) give_up("halt grant");
      @(negedge clk);
    end
    m = 0;
    repeat (600) begin
      @(negedge clk);
      if (bus_out.select_ack_oe_n !== 1'h1) m++;
    end
    `SBMTC_CHK("halt_self_ack", 0, m)
    ack      = 1'h1;
    grant_rq = 1'h0;
    repeat (4) @(negedge clk);
    `SBMTC_CHK("halt_grant_drop", 1'h1, pgrant_n)
    halt_n = 1'h1;
    $display("test halt grant done");
    stop_test();
  end
endmodule : sbmtc_xfer_ctrl_tb_top
